// ---- core/windowed_dram_controller.sv ----
// windowed dram controller: boundary load, access and cas-before-ras refresh
`timescale 1ns/100ps
`default_nettype none

// How it works
// - the block runs refresh, access, reset and address mapping for a 4 MB dram.
// - the dram sits in one of 16 banks picked by address bits 25 to 22.
// - three state machines sequence i/o loads, memory cycles and pending refresh.
// - the memory machine uses gray-style codes whose bits drive the strobes directly.
// - an i/o write from the host loads both the lower and the upper window bound.
// - an in-window request runs a read or write cycle with ras, mux switch and cas.
// - with no access running, a refresh request runs at once with cas before ras.
// - a refresh arriving mid-cycle is held and granted once the cycle finishes.
// - reset beats every other request and sends all machines back to idle.
// - the bound write takes the lower bound from data 3:0 and the upper from 7:4.
// - an address hits when its bank is at least the lower and below the upper bound.
// - the dram address is bits 21:12 as row and bits 11:2 as column.
module windowed_dram_controller
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// host bus, all asynchronous to clk
	input wire dram_ctrl_pkg::host_req_t hostIn,
	// host handshake
	output logic readyB,
	// dram drive
	output var dram_ctrl_pkg::dram_drv_t dramOut
);
	// ==========================================================
	// input synchronisers
	dram_ctrl_pkg::host_req_t sync1_q;
	dram_ctrl_pkg::host_req_t sync2_q;
	dram_ctrl_pkg::host_req_t req;

	// two flops on every host pin before any logic reads it
	always_ff @(posedge clk)
	begin
		sync1_q <= hostIn;
		sync2_q <= sync1_q;
	end
	assign req = sync2_q;

	// window test on the bank bits
	function automatic logic inWindow(input logic [3:0] bank, input logic [3:0] lo,
		input logic [3:0] hi);
		inWindow = (bank >= lo) && (bank < hi);
	endfunction

	// ==========================================================
	// i/o machine: boundary load
	dram_ctrl_pkg::io_state_t ioState_q, ioState_d;
	logic [3:0] lowBound_q, lowBound_d;
	logic [3:0] upBound_q, upBound_d;

	// an i/o write (memSel low, readB low, strobe low) loads the window
	always_comb
	begin
		ioState_d = ioState_q;
		lowBound_d = lowBound_q;
		upBound_d = upBound_q;
		case (ioState_q)
			dram_ctrl_pkg::IO_IDLE:
				if (!req.memSel && !req.readB && !req.strobeB)
					ioState_d = dram_ctrl_pkg::IO_LOAD;
			dram_ctrl_pkg::IO_LOAD:
			begin
				lowBound_d = req.data[dram_ctrl_pkg::BOUND_LO_HI:0];
				upBound_d = req.data[dram_ctrl_pkg::BOUND_HI_HI:dram_ctrl_pkg::BOUND_HI_LO];
				ioState_d = dram_ctrl_pkg::IO_DONE;
			end
			dram_ctrl_pkg::IO_DONE:
				ioState_d = dram_ctrl_pkg::IO_IDLE;
			default:
				ioState_d = dram_ctrl_pkg::IO_IDLE;
		endcase
	end

	// reset wins over any load in progress
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			ioState_q <= dram_ctrl_pkg::IO_IDLE;
			lowBound_q <= dram_ctrl_pkg::BOUND_RST;
			upBound_q <= dram_ctrl_pkg::BOUND_RST;
		end
		else
		begin
			ioState_q <= ioState_d;
			lowBound_q <= lowBound_d;
			upBound_q <= upBound_d;
		end
	end

	// ==========================================================
	// memory machine: access and refresh cycles
	dram_ctrl_pkg::mem_state_t memState_q, memState_d;
	logic wrEn_q, wrEn_d;
	logic refPend_q, refPend_d;
	logic strobeHeldB_q, strobeHeldB_d;
	logic hit;
	logic inAccess;

	assign hit = inWindow(req.addr[dram_ctrl_pkg::BANK_HI:dram_ctrl_pkg::BANK_LO],
		lowBound_q, upBound_q);

	// access states: a live strobe here belongs to the cycle already running
	assign inAccess = (memState_q == dram_ctrl_pkg::M_CHECK)
		|| (memState_q == dram_ctrl_pkg::M_ROW)
		|| (memState_q == dram_ctrl_pkg::M_COL)
		|| (memState_q == dram_ctrl_pkg::M_CAS)
		|| (memState_q == dram_ctrl_pkg::M_DONE);

	// pending refresh beats a new access; out-of-window requests drop back to idle
	always_comb
	begin
		memState_d = memState_q;
		wrEn_d = wrEn_q;
		case (memState_q)
			dram_ctrl_pkg::M_IDLE:
			begin
				wrEn_d = 1'b1;
				if (refPend_q)
					memState_d = dram_ctrl_pkg::M_RCAS;
				else if ((!req.strobeB || !strobeHeldB_q) && req.memSel)
					memState_d = dram_ctrl_pkg::M_CHECK;
			end
			dram_ctrl_pkg::M_CHECK:
				memState_d = hit ? dram_ctrl_pkg::M_ROW : dram_ctrl_pkg::M_IDLE;
			dram_ctrl_pkg::M_ROW:
				memState_d = dram_ctrl_pkg::M_COL;
			dram_ctrl_pkg::M_COL:
			begin
				memState_d = dram_ctrl_pkg::M_CAS;
				wrEn_d = req.readB; // write enable active low on a write
			end
			dram_ctrl_pkg::M_CAS:
				memState_d = dram_ctrl_pkg::M_DONE;
			dram_ctrl_pkg::M_DONE:
				memState_d = dram_ctrl_pkg::M_IDLE;
			dram_ctrl_pkg::M_RCAS:
				memState_d = dram_ctrl_pkg::M_RRAS;
			dram_ctrl_pkg::M_RRAS:
				memState_d = dram_ctrl_pkg::M_RHOLD;
			dram_ctrl_pkg::M_RHOLD:
				memState_d = dram_ctrl_pkg::M_REND;
			dram_ctrl_pkg::M_REND:
				memState_d = dram_ctrl_pkg::M_IDLE;
			default:
				memState_d = dram_ctrl_pkg::M_IDLE;
		endcase
	end

	// ==========================================================
	// pending machine: refresh request and strobe latch
	// a new refresh request wins over the clear at refresh end
	always_comb
	begin
		refPend_d = refPend_q;
		strobeHeldB_d = strobeHeldB_q;
		if (memState_q == dram_ctrl_pkg::M_REND)
			refPend_d = 1'b0;
		if (req.refReq)
			refPend_d = 1'b1;
		// the check state uses up a held strobe, hit or miss, so a miss cannot loop
		if (memState_q == dram_ctrl_pkg::M_CHECK)
			strobeHeldB_d = 1'b1;
		// keep a strobe seen in idle or refresh so the access runs afterwards;
		// one seen mid-access is the running request and would replay it
		if (refPend_q && !req.strobeB && req.memSel && !inAccess)
			strobeHeldB_d = 1'b0;
	end

	// memory and pending state
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			memState_q <= dram_ctrl_pkg::M_IDLE;
			wrEn_q <= 1'b1;
			refPend_q <= 1'b0;
			strobeHeldB_q <= 1'b1;
		end
		else
		begin
			memState_q <= memState_d;
			wrEn_q <= wrEn_d;
			refPend_q <= refPend_d;
			strobeHeldB_q <= strobeHeldB_d;
		end
	end

	// ==========================================================
	// registered outputs, decoded straight from next-state bits
	dram_ctrl_pkg::dram_drv_t drv_d;
	logic readyB_d;

	// gray codes make each strobe a single state bit
	always_comb
	begin
		drv_d.rasB = memState_d[0];
		drv_d.casB = memState_d[2];
		drv_d.wrEn = wrEn_d;
		// bit1 stays high through idle, check and row, so the row is out as ras falls
		drv_d.addr = memState_d[1] ? req.addr[dram_ctrl_pkg::ROW_HI:dram_ctrl_pkg::ROW_LO]
			: req.addr[dram_ctrl_pkg::COL_HI:dram_ctrl_pkg::COL_LO];
		readyB_d = !((ioState_d == dram_ctrl_pkg::IO_DONE) || !memState_d[3]);
	end

	// one flop per output so pins never glitch
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			dramOut <= '{rasB: 1'b1, casB: 1'b1, wrEn: 1'b1, addr: 10'h000};
			readyB <= 1'b1;
		end
		else
		begin
			dramOut <= drv_d;
			readyB <= readyB_d;
		end
	end
endmodule
`default_nettype wire

// ---- common/dram_ctrl_pkg.sv ----
// shared constants, state codes and bundles for the windowed dram controller
package dram_ctrl_pkg;
	// ==========================================================
	// address layout
	localparam int BANK_HI = 25;
	localparam int BANK_LO = 22;
	localparam int ROW_HI = 21;
	localparam int ROW_LO = 12;
	localparam int COL_HI = 11;
	localparam int COL_LO = 2;
	localparam int BOUND_LO_HI = 3;
	localparam int BOUND_HI_HI = 7;
	localparam int BOUND_HI_LO = 4;
	localparam logic [3:0] BOUND_RST = 4'h0;

	// ==========================================================
	// i/o state machine, one-hot
	typedef enum logic [2:0]
	{
		IO_IDLE = 3'b001,
		IO_LOAD = 3'b010,
		IO_DONE = 3'b100
	} io_state_t;

	// ==========================================================
	// memory state machine; gray-style codes whose bits are the strobes
	// bit0 ras_b, bit1 row select, bit2 cas_b, bit3 mem done_b, bit4 refresh idle
	typedef enum logic [6:0]
	{
		M_IDLE = 7'h7F,
		M_CHECK = 7'h5F,
		M_ROW = 7'h5E,
		M_COL = 7'h5C,
		M_CAS = 7'h58,
		M_DONE = 7'h50,
		M_RCAS = 7'h6B,
		M_RRAS = 7'h6A,
		M_RHOLD = 7'h4A,
		M_REND = 7'h0F
	} mem_state_t;

	// host request bundle
	typedef struct packed
	{
		logic [25:2] addr;
		logic [7:0] data;
		logic strobeB;
		logic readB;
		logic memSel;
		logic refReq;
	} host_req_t;

	// dram drive bundle
	typedef struct packed
	{
		logic rasB;
		logic casB;
		logic wrEn;
		logic [9:0] addr;
	} dram_drv_t;
endpackage

// ---- test/windowed_dram_controller_props.sv ----
// port assertions for the windowed dram controller
`timescale 1ns/100ps
`default_nettype none
module windowed_dram_controller_props
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// watched ports
	input wire dram_ctrl_pkg::host_req_t hostIn,
	input wire logic readyB,
	input wire dram_ctrl_pkg::dram_drv_t dramOut
);
	// ==========================================
	// one domain: clock and reset given once
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// reset needs its own disable or it could never fire
	reset_idle_a: assert property (disable iff (1'b0) !rst_b
		|=> dramOut.rasB && dramOut.casB && readyB)
		else $error("strobes active after reset");
	ready_pulse_a: assert property (!readyB |=> readyB)
		else $error("ready longer than one cycle");
	cas_first_a: assert property ($fell(dramOut.casB) && dramOut.rasB
		|=> !dramOut.rasB && !dramOut.casB)
		else $error("refresh ras did not follow cas");
	refresh_quiet_a: assert property ($fell(dramOut.casB) && dramOut.rasB
		|-> readyB [*4])
		else $error("ready during refresh");
	row_addr_a: assert property ($fell(dramOut.rasB) && dramOut.casB
		|-> dramOut.addr == hostIn.addr[21:12])
		else $error("row address wrong");
	ras_hold_a: assert property ($fell(dramOut.rasB) && dramOut.casB
		|-> !dramOut.rasB [*3])
		else $error("ras released early");
	col_addr_a: assert property ($fell(dramOut.casB) && !dramOut.rasB
		|-> dramOut.addr == hostIn.addr[11:2])
		else $error("column address wrong");
	write_level_a: assert property ($fell(dramOut.casB) && !dramOut.rasB
		|-> dramOut.wrEn == hostIn.readB)
		else $error("write enable wrong");
	access_ready_a: assert property ($fell(dramOut.casB) && !dramOut.rasB
		|-> ##[0:2] !readyB)
		else $error("no ready after access");
	cover property ($fell(dramOut.casB) && dramOut.rasB);
	cover property ($fell(dramOut.casB) && !dramOut.rasB && !hostIn.readB);
	cover property (!readyB && dramOut.rasB);
endmodule
bind windowed_dram_controller windowed_dram_controller_props props_i (.clk(clk), .rst_b(rst_b),
	.hostIn(hostIn), .readyB(readyB), .dramOut(dramOut));
`default_nettype wire

// ---- test/dram_model.sv ----
// behavioural dram model counting refresh and access strobes
`timescale 1ns/100ps
`default_nettype none
module dram_model
(
	// clock
	input wire logic clk,
	// strobes from the controller
	input wire dram_ctrl_pkg::dram_drv_t dramIn,
	// event counts
	output var int refCount,
	output var int accCount
);
	logic casQ = 1'b1;
	initial refCount = 0;
	initial accCount = 0;
	// cas falling with ras still high marks a refresh
	always @(posedge clk)
	begin
		if (casQ && !dramIn.casB && dramIn.rasB) refCount <= refCount + 1;
		if (casQ && !dramIn.casB && !dramIn.rasB) accCount <= accCount + 1;
		casQ <= dramIn.casB;
	end
endmodule
`default_nettype wire

// ---- test/windowed_dram_controller_tb.sv ----
// self-checking bench for the windowed dram controller
`timescale 1ns/100ps
`default_nettype none
module windowed_dram_controller_tb;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	dram_ctrl_pkg::host_req_t hostIn;
	logic readyB;
	dram_ctrl_pkg::dram_drv_t dramOut;
	int refCount, accCount, n, m, lo, hi, seen, fail_count = 0, total_checks = 0, cycles = 0;
	logic [31:0] rng = 32'h0000E302;
	logic [31:0] r;
	logic [7:0] bnd [3] = '{8'h93, 8'h55, 8'hF0};
	always #2.5 clk = ~clk;
	windowed_dram_controller uut (.clk(clk), .rst_b(rst_b), .hostIn(hostIn), .readyB(readyB),
		.dramOut(dramOut));
	dram_model far (.clk(clk), .dramIn(dramOut), .refCount(refCount), .accCount(accCount));
	// ==========================================
	// helpers
	function logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	task check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (exp !== got)
		begin
			fail_count++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task complete_run();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// strobe held three cycles, released before the cycle ends; ready pulses counted
	task host(input logic mem, input logic rd, input logic [25:2] a, input logic [7:0] d);
		@(negedge clk);
		hostIn.memSel = mem;
		hostIn.readB = rd;
		hostIn.addr = a;
		hostIn.data = d;
		hostIn.strobeB = 1'b0;
		repeat (3) @(negedge clk);
		hostIn.strobeB = 1'b1;
		seen = 0;
		repeat (14)
		begin
			@(negedge clk);
			if (readyB === 1'b0) seen++;
		end
	endtask
	task ref_pulse();
		@(negedge clk);
		hostIn.refReq = 1'b1;
		@(negedge clk);
		hostIn.refReq = 1'b0;
	endtask
	// hang guard
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fail_count++;
			complete_run();
		end
	end
	// ==========================================
	// main sequence
	initial
	begin
		hostIn = '0;
		hostIn.strobeB = 1'b1;
		repeat (5) @(negedge clk);
		rst_b = 1'b1;
		host(1'b1, 1'b1, 24'h000000, 8'h00);
		check("ready unloaded", 0, seen);
		foreach (bnd[k])
		begin
			host(1'b0, 1'b0, 24'h000000, bnd[k]);
			check("io ready", 1, seen);
			lo = bnd[k] & 15;
			hi = bnd[k] >> 4;
			for (int b = 0; b < 16; b++)
			begin
				n = accCount;
				r = xs();
				host(1'b1, r[31], {b[3:0], r[19:0]}, 8'h00);
				check("access ready", b >= lo && b < hi, seen);
				check("dram access", b >= lo && b < hi, accCount - n);
			end
		end
		n = refCount;
		ref_pulse();
		repeat (10) @(negedge clk);
		check("idle refresh", 1, refCount - n);
		// refresh raised mid-access must wait, not be lost
		n = refCount;
		m = accCount;
		fork
			host(1'b1, 1'b0, 24'h4ABCDE, 8'h00);
			begin
				repeat (4) @(negedge clk);
				ref_pulse();
			end
		join
		check("pending ready", 1, seen);
		check("pending refresh", 1, refCount - n);
		check("pending access", 1, accCount - m);
		// a strobe that lands during refresh is held and served right after it
		n = refCount;
		m = accCount;
		fork
			ref_pulse();
			begin
				@(negedge clk);
				host(1'b1, 1'b1, 24'h512345, 8'h00);
			end
		join
		check("held ready", 1, seen);
		check("held refresh", 1, refCount - n);
		check("held access", 1, accCount - m);
		// reset mid-access cancels the cycle and clears the bounds
		fork
			host(1'b1, 1'b1, 24'h400000, 8'h00);
			begin
				repeat (5) @(negedge clk);
				rst_b = 1'b0;
				repeat (2) @(negedge clk);
				rst_b = 1'b1;
			end
		join
		check("reset abort", 0, seen);
		host(1'b1, 1'b1, 24'h400000, 8'h00);
		check("bounds cleared", 0, seen);
		complete_run();
	end
endmodule
`default_nettype wire
